// ===== src/agoc_top.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module agoc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic adc_enable,
  input wire logic conversion_start_bit,
  input wire logic conversion_stop_bit,
  input wire logic mod_valid,
  input wire logic mod_bit,
  input wire logic [15:0] high_threshold_value,
  input wire logic [15:0] low_threshold_value,
  input wire logic conv_valid,
  input wire logic signed [23:0] conv_data,
  output logic cal_valid,
  output logic signed [23:0] cal_data,
  output logic overcurrent_fault_output,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0] gain_trim_word;
  agoc_pkg::agoc_cfg_t cfg;
  logic shared_pin_source_select;
  logic shared_pin_output_format;
  logic [agoc_pkg::IRQ_W-1:0] irq_status;
  logic [agoc_pkg::IRQ_W-1:0] irq_mask;
  logic [15:0] next_gain_trim_word;
  agoc_pkg::agoc_cfg_t next_cfg;
  logic next_src_sel;
  logic next_fmt;
  logic [agoc_pkg::IRQ_W-1:0] next_irq_status;
  logic [agoc_pkg::IRQ_W-1:0] next_irq_mask;
  logic [15:0] next_reg_rdata;
  agoc_pkg::agoc_trip_t trip;
  agoc_pkg::agoc_trip_t trip_d;
  logic [agoc_pkg::IRQ_W-1:0] irq_event;
  logic run;

  assign run = cfg.en && adc_enable;
  assign irq_event = {overcurrent_fault_output && !(trip_d.high || trip_d.low),
                      trip.low && !trip_d.low, trip.high && !trip_d.high};

  always_comb begin
    next_gain_trim_word = gain_trim_word;
    next_cfg = cfg;
    next_src_sel = shared_pin_source_select;
    next_fmt = shared_pin_output_format;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_reg_rdata = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        agoc_pkg::GAIN_TRIM_OFS: next_gain_trim_word = reg_wdata;
        agoc_pkg::OVC_CFG_OFS: next_cfg = reg_wdata[15:8];
        agoc_pkg::PIN_CTRL_OFS: begin
          next_src_sel = reg_wdata[0];
          next_fmt = reg_wdata[1];
        end
        agoc_pkg::IRQ_STATUS_OFS: next_irq_status = irq_status & ~reg_wdata[2:0];
        agoc_pkg::IRQ_MASK_OFS: next_irq_mask = reg_wdata[2:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // Hardware set wins over software clear
    next_irq_status = next_irq_status | irq_event;
    if (reg_rd) begin
      case (reg_addr)
        agoc_pkg::GAIN_TRIM_OFS: next_reg_rdata = gain_trim_word;
        agoc_pkg::OVC_CFG_OFS: next_reg_rdata = {cfg, 8'h00};
        agoc_pkg::PIN_CTRL_OFS: next_reg_rdata = {14'h0000, shared_pin_output_format,
                                                  shared_pin_source_select};
        agoc_pkg::IRQ_STATUS_OFS: next_reg_rdata = {13'h0000, irq_status};
        agoc_pkg::IRQ_MASK_OFS: next_reg_rdata = {13'h0000, irq_mask};
        agoc_pkg::TRIP_STATE_OFS: next_reg_rdata = {13'h0000, overcurrent_fault_output,
                                                    trip.low, trip.high};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gain_trim_word <= agoc_pkg::GAIN_TRIM_RST;
      cfg <= agoc_pkg::OVC_CFG_RST[15:8];
      shared_pin_source_select <= 1'b0;
      shared_pin_output_format <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      reg_rdata <= 16'h0000;
    end else begin
      gain_trim_word <= next_gain_trim_word;
      cfg <= next_cfg;
      shared_pin_source_select <= next_src_sel;
      shared_pin_output_format <= next_fmt;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Gain correction on main path
  logic signed [41:0] prod;
  logic signed [25:0] scaled;
  logic signed [23:0] next_cal_data;

  always_comb begin
    prod = conv_data * $signed({1'b0, agoc_pkg::GAIN_ONE} +
                               {{2{gain_trim_word[15]}}, gain_trim_word});
    scaled = prod[41:16];
    if (scaled > 26'(agoc_pkg::DATA_MAX)) next_cal_data = agoc_pkg::DATA_MAX;
    else if (scaled < 26'(agoc_pkg::DATA_MIN)) next_cal_data = agoc_pkg::DATA_MIN;
    else next_cal_data = scaled[23:0];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_valid <= 1'b0;
      cal_data <= '0;
    end else begin
      cal_valid <= conv_valid;
      cal_data <= conv_valid ? next_cal_data : cal_data;
    end
  end

  gain_unity_a: assert property (@(posedge mclk) disable iff (rst)
    conv_valid && gain_trim_word == 16'h0000 |=> cal_valid && cal_data == $past(conv_data))
    else $error("unity gain altered data");
  gain_sat_a: assert property (@(posedge mclk) disable iff (rst)
    conv_valid && gain_trim_word == 16'h7fff && conv_data == 24'sh7fffff
      |=> cal_data == 24'sh7fffff) else $error("gain result not saturated");
  gain_half_a: assert property (@(posedge mclk) disable iff (rst)
    conv_valid && gain_trim_word == 16'h8000 && conv_data == 24'sh000100
      |=> cal_data == 24'sh000080) else $error("half gain wrong");

  ////////////////////////////////////////////////////////////////////////
  // Fast filter, free of start and stop bits
  typedef logic signed [agoc_pkg::FF_ACC_W-1:0] agoc_acc_t;
  agoc_acc_t integ [3];
  agoc_acc_t dly [3];
  agoc_acc_t next_integ [3];
  agoc_acc_t next_dly [3];
  agoc_acc_t comb_v [4];
  logic [agoc_pkg::FF_DEC_W-1:0] dec_cnt;
  logic [agoc_pkg::FF_DEC_W-1:0] next_dec_cnt;
  logic ff_stb;
  logic next_ff_stb;
  logic signed [15:0] ff_val;
  logic signed [15:0] next_ff_val;
  agoc_acc_t shifted;

  always_comb begin
    next_integ = integ;
    next_dly = dly;
    next_dec_cnt = dec_cnt;
    next_ff_stb = 1'b0;
    next_ff_val = ff_val;
    comb_v[0] = integ[2];
    for (int i = 0; i < 3; i++) begin
      comb_v[i+1] = comb_v[i] - dly[i];
    end
    shifted = comb_v[3] >>> agoc_pkg::FF_SHIFT;
    if (!run) begin
      for (int i = 0; i < 3; i++) begin
        next_integ[i] = '0;
        next_dly[i] = '0;
      end
      next_dec_cnt = '0;
    end else if (mod_valid) begin
      next_integ[0] = integ[0] + (mod_bit ? agoc_acc_t'(1) : agoc_acc_t'(-1));
      next_integ[1] = integ[1] + integ[0];
      next_integ[2] = integ[2] + integ[1];
      next_dec_cnt = dec_cnt + 1'b1;
      if (dec_cnt == '1) begin
        for (int i = 0; i < 3; i++) begin
          next_dly[i] = comb_v[i];
        end
        next_ff_stb = 1'b1;
        if (shifted > agoc_acc_t'(32767)) next_ff_val = 16'sh7fff;
        else next_ff_val = shifted[15:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        integ[i] <= '0;
        dly[i] <= '0;
      end
      dec_cnt <= '0;
      ff_stb <= 1'b0;
      ff_val <= '0;
    end else begin
      integ <= next_integ;
      dly <= next_dly;
      dec_cnt <= next_dec_cnt;
      ff_stb <= next_ff_stb;
      ff_val <= next_ff_val;
    end
  end

  ff_off_a: assert property (@(posedge mclk) disable iff (rst)
    !run |=> !ff_stb && dec_cnt == '0) else $error("fast filter ran while off");
  ff_rate_a: assert property (@(posedge mclk) disable iff (rst)
    ff_stb |-> dec_cnt == '0 && $past(dec_cnt) == '1) else $error("decimation ratio wrong");
  ff_free_a: assert property (@(posedge mclk) disable iff (rst)
    run && mod_valid && (conversion_start_bit || conversion_stop_bit)
      |=> dec_cnt == $past(dec_cnt) + 1'b1) else $error("filter held by start or stop");

  ////////////////////////////////////////////////////////////////////////
  // Comparator with deglitch counters
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [7:0] next_hi_cnt;
  logic [7:0] next_lo_cnt;
  agoc_pkg::agoc_trip_t next_trip;
  logic [7:0] need;
  logic above;
  logic below;

  always_comb begin
    need = agoc_pkg::deglitch_len(cfg.num);
    above = ff_val > $signed(high_threshold_value) &&
            high_threshold_value != agoc_pkg::TH_POS_FS;
    below = ff_val < $signed(low_threshold_value) &&
            low_threshold_value != agoc_pkg::TH_NEG_FS;
    next_hi_cnt = hi_cnt;
    next_lo_cnt = lo_cnt;
    next_trip = trip;
    if (!run) begin
      next_hi_cnt = '0;
      next_lo_cnt = '0;
      next_trip = '0;
    end else if (ff_stb) begin
      next_hi_cnt = above ? ((hi_cnt < need) ? hi_cnt + 8'h01 : hi_cnt) : 8'h00;
      next_lo_cnt = below ? ((lo_cnt < need) ? lo_cnt + 8'h01 : lo_cnt) : 8'h00;
      next_trip.high = above && next_hi_cnt >= need;
      next_trip.low = below && next_lo_cnt >= need;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      trip <= '0;
      trip_d <= '0;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      trip <= next_trip;
      trip_d <= trip;
    end
  end

  first_trip_a: assert property (@(posedge mclk) disable iff (rst)
    run && ff_stb && cfg.num == 5'h00 && above |=> trip.high)
    else $error("single conversion did not trip");
  no_early_a: assert property (@(posedge mclk) disable iff (rst)
    run && ff_stb && cfg.num == 5'h02 && hi_cnt == 8'h00 |=> !trip.high)
    else $error("tripped before deglitch count");
  inside_clear_a: assert property (@(posedge mclk) disable iff (rst)
    run && ff_stb && !below |=> lo_cnt == 8'h00 && !trip.low)
    else $error("low counter not restarted");
  low_disable_a: assert property (@(posedge mclk) disable iff (rst)
    low_threshold_value == agoc_pkg::TH_NEG_FS && ff_stb |=> !trip.low)
    else $error("low detection not disabled");
  adc_off_a: assert property (@(posedge mclk) disable iff (rst)
    !adc_enable |=> !trip.high && !trip.low) else $error("trip with adc off");

  ////////////////////////////////////////////////////////////////////////
  // Fault output and shared pin
  logic fault_level;

  assign overcurrent_fault_output = trip.high || trip.low;
  assign fault_level = overcurrent_fault_output ? cfg.pol : !cfg.pol;

  always_comb begin
    shared_pin_out = 1'b0;
    shared_pin_oe = 1'b0;
    if (shared_pin_source_select) begin
      shared_pin_out = shared_pin_output_format ? 1'b0 : fault_level;
      shared_pin_oe = shared_pin_output_format ? !fault_level : 1'b1;
    end
  end

  pin_level_a: assert property (@(posedge mclk) disable iff (rst)
    shared_pin_source_select && !shared_pin_output_format && trip.high
      |-> shared_pin_oe && shared_pin_out == cfg.pol) else $error("fault level wrong");
  irq_set_a: assert property (@(posedge mclk) disable iff (rst)
    trip.high && !trip_d.high |=> irq_status[agoc_pkg::IRQ_HIGH])
    else $error("high event not latched");
endmodule
`default_nettype wire

// ===== src/agoc_pkg.sv
package agoc_pkg;
  // Register indices
  localparam logic [7:0] GAIN_TRIM_OFS = 8'h86;
  localparam logic [7:0] OVC_CFG_OFS = 8'h87;
  localparam logic [7:0] PIN_CTRL_OFS = 8'hf0;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'hf1;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hf2;
  localparam logic [7:0] TRIP_STATE_OFS = 8'hf3;
  // Reset values
  localparam logic [15:0] GAIN_TRIM_RST = 16'h0000;
  localparam logic [15:0] OVC_CFG_RST = 16'h0000;
  // Config field positions
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_POL_BIT = 14;
  localparam int CFG_RSV_BIT = 13;
  localparam int CFG_NUM_LSB = 8;
  // Interrupt bits
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  // Fast filter: third-order sinc, fixed ratio
  localparam int FF_OSR = 64;
  localparam int FF_DEC_W = $clog2(FF_OSR);
  localparam int FF_ACC_W = 3 * FF_DEC_W + 2;
  localparam int FF_SHIFT = 3;
  localparam logic [15:0] TH_POS_FS = 16'h7fff;
  localparam logic [15:0] TH_NEG_FS = 16'h8000;
  localparam logic signed [23:0] DATA_MAX = 24'sh7fffff;
  localparam logic signed [23:0] DATA_MIN = -24'sh800000;
  localparam logic [16:0] GAIN_ONE = 17'h10000;

  typedef struct packed {
    logic en;
    logic pol;
    logic rsv;
    logic [4:0] num;
  } agoc_cfg_t;

  typedef struct packed {
    logic high;
    logic low;
  } agoc_trip_t;

  // Deglitch code to conversion count
  function automatic logic [7:0] deglitch_len(input logic [4:0] code);
    logic [7:0] n;
    n = 8'h01;
    case (code)
      5'h07: n = 8'h08;
      5'h08: n = 8'h09;
      5'h13: n = 8'h20;
      5'h14: n = 8'h28;
      5'h15: n = 8'h30;
      5'h16: n = 8'h38;
      5'h17: n = 8'h40;
      5'h18: n = 8'h48;
      5'h19: n = 8'h50;
      5'h1a: n = 8'h58;
      5'h1b: n = 8'h60;
      5'h1c: n = 8'h68;
      5'h1d: n = 8'h70;
      5'h1e: n = 8'h78;
      5'h1f: n = 8'h80;
      default: begin
        if (code < 5'h07) n = {3'h0, code} + 8'h01;
        else n = {2'h0, code, 1'b0} - 8'h08;
      end
    endcase
    return n;
  endfunction
endpackage

// ===== bench/agoc_mod_src.sv
`timescale 1ns/1ps
`default_nettype none
// Modulator bit source for the fast filter path
module agoc_mod_src (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic level,
  input wire logic slow,
  output logic mod_valid,
  output logic mod_bit
);
  logic ph;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph <= 1'b0;
      mod_valid <= 1'b0;
      mod_bit <= 1'b0;
    end else begin
      ph <= ~ph;
      if (run && (!slow || ph)) begin
        mod_valid <= 1'b1;
        mod_bit <= level;
      end else begin
        // Idle bit is not held stable
        mod_valid <= 1'b0;
        mod_bit <= ~mod_bit;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/agoc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module agoc_top_tb;
  logic mclk, rst, reg_wr, reg_rd, adc_en, st, sp, conv_valid, cal_valid;
  logic run, level, slow, mod_valid, mod_bit, fault, pin_out, pin_oe, irq;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, hi_th, lo_th;
  logic [23:0] conv_data, cal_data;
  int num_errors, checks;
  localparam logic [7:0] CFG = agoc_pkg::OVC_CFG_OFS;
  localparam logic [7:0] PIN = agoc_pkg::PIN_CTRL_OFS;
  localparam logic [7:0] TRIP = agoc_pkg::TRIP_STATE_OFS;
  agoc_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_enable(adc_en),
    .conversion_start_bit(st), .conversion_stop_bit(sp), .mod_valid(mod_valid),
    .mod_bit(mod_bit), .high_threshold_value(hi_th), .low_threshold_value(lo_th),
    .conv_valid(conv_valid), .conv_data(conv_data), .cal_valid(cal_valid),
    .cal_data(cal_data), .overcurrent_fault_output(fault), .shared_pin_out(pin_out),
    .shared_pin_oe(pin_oe), .irq(irq));
  agoc_mod_src model (.mclk(mclk), .rst(rst), .run(run), .level(level), .slow(slow),
    .mod_valid(mod_valid), .mod_bit(mod_bit));
  //////////////////////////////
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read until match or tries run out
  task automatic poll(input logic [7:0] a, input logic [15:0] e, input int n);
    logic [15:0] got;
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (30) @(posedge mclk);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      // Read data stand only in this cycle
      got = reg_rdata;
      if (got === e) break;
    end
    `CHK(got, e)
    if (n > 1 && got !== e) end_of_test();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    poll(a, e, 1);
  endtask
  task automatic wait_for(input logic want, input int lim);
    int n;
    n = 0;
    while (fault !== want && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (fault !== want) begin
      `CHK(fault, want)
      end_of_test();
    end
  endtask
  task automatic hold_off(input int n);
    repeat (n) begin
      @(negedge mclk);
      `CHK(fault, 1'b0)
    end
  endtask
  task automatic pin(input logic o, input logic e);
    @(posedge mclk);
    #1;
    `CHK(pin_out, o)
    `CHK(pin_oe, e)
  endtask
  function automatic logic [23:0] gexp(input logic [15:0] g, input logic [23:0] d);
    longint p;
    p = (longint'($signed(d)) * (longint'(65536) + longint'($signed(g)))) >>> 16;
    if (p > 64'sh7fffff) p = 64'sh7fffff;
    if (p < -64'sh800000) p = -64'sh800000;
    return p[23:0];
  endfunction
  task automatic conv(input logic [15:0] g, input logic [23:0] d);
    wr(agoc_pkg::GAIN_TRIM_OFS, g);
    @(posedge mclk);
    conv_valid <= 1'b1;
    conv_data <= d;
    @(posedge mclk);
    conv_valid <= 1'b0;
    #1;
    `CHK(cal_valid, 1'b1)
    `CHK(cal_data, gexp(g, d))
  endtask
  //////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, adc_en, st, sp, conv_valid, run, level, slow} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    conv_data = 24'h000000;
    hi_th = 16'h7fff;
    lo_th = 16'h8000;
    num_errors = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(agoc_pkg::GAIN_TRIM_OFS, 16'h0000);
    rd(CFG, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(CFG, 16'hdfff);
    rd(CFG, 16'hdf00);
    wr(CFG, 16'h0000);
    conv(16'h0000, 24'h123456);
    conv(16'h8000, 24'h123456);
    conv(16'h8000, 24'h000100);
    conv(16'hffff, 24'hc00001);
    conv(16'h7fff, 24'h7fffff);
    conv(16'h7fff, 24'h800000);
    rd(agoc_pkg::GAIN_TRIM_OFS, 16'h7fff);
    // High trip, start and stop bits set, push-pull pin
    @(posedge mclk);
    adc_en <= 1'b1;
    st <= 1'b1;
    sp <= 1'b1;
    hi_th <= 16'h1000;
    run <= 1'b1;
    level <= 1'b1;
    wr(PIN, 16'h0001);
    wr(CFG, 16'h8200);
    hold_off(188);
    pin(1'b1, 1'b1);
    wait_for(1'b1, 600);
    pin(1'b0, 1'b1);
    rd(TRIP, 16'h0005);
    `CHK(irq, 1'b0)
    wr(agoc_pkg::IRQ_MASK_OFS, 16'h0004);
    pin(1'b0, 1'b1);
    `CHK(irq, 1'b1)
    wr(agoc_pkg::IRQ_STATUS_OFS, 16'h0004);
    pin(1'b0, 1'b1);
    `CHK(irq, 1'b0)
    wr(CFG, 16'hc200);
    pin(1'b1, 1'b1);
    wr(CFG, 16'h8200);
    wr(PIN, 16'h0003);
    pin(1'b0, 1'b1);
    wr(PIN, 16'h0000);
    @(posedge mclk);
    #1;
    `CHK(pin_oe, 1'b0)
    // Low trip from a slow source
    @(posedge mclk);
    level <= 1'b0;
    slow <= 1'b1;
    lo_th <= 16'hc000;
    poll(TRIP, 16'h0006, 60);
    @(posedge mclk);
    lo_th <= 16'h8000;
    poll(TRIP, 16'h0000, 60);
    @(posedge mclk);
    level <= 1'b1;
    slow <= 1'b0;
    hi_th <= 16'h7fff;
    hold_off(600);
    @(posedge mclk);
    hi_th <= 16'h1000;
    wait_for(1'b1, 600);
    wr(CFG, 16'h0200);
    wait_for(1'b0, 4);
    hold_off(400);
    @(posedge mclk);
    adc_en <= 1'b0;
    wr(CFG, 16'h8a00);
    hold_off(600);
    // Deglitch codes 10 and 0 from a cleared filter
    @(posedge mclk);
    adc_en <= 1'b1;
    hold_off(768);
    wait_for(1'b1, 4);
    wr(CFG, 16'h0000);
    wr(CFG, 16'h8000);
    hold_off(64);
    wait_for(1'b1, 4);
    end_of_test();
  end
endmodule
`default_nettype wire
